// ### hw/dtc_top.sv
// Dual 16-bit timer/counter with register port and interrupt requests
//
// Function
// RULE1: timer counts once per twelve core clocks
// RULE2: falling edge seen over two machine cycles
// RULE3: source bit picks pin edges or cycles
// RULE4: gate bit adds pin-high qualification
// RULE5: two-bit mode field selects four modes
// RULE6: mode 0 is 5-bit prescaler plus byte
// RULE7: wrap to zero sets overflow flag
// RULE8: count only when run and gate ok
// RULE9: run bit never changes the count
// RULE10: mode 1 uses full sixteen bits
// RULE11: mode 2 reloads low byte from high
// RULE12: unit 1 mode 3 freezes count
// RULE13: unit 0 low byte independent in mode 3
// RULE14: unit 0 high byte uses unit 1 controls
// RULE15: unit 1 still counts, without flag
// RULE16: flags set by hardware, cleared twice ways
// RULE17: run bit starts and stops counting
// RULE18: external interrupt bits in low nibble
// RULE19: overflow flags exported, acknowledge clears
`timescale 1ns/1ns
`default_nettype none

module dtc_top (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // External pins
  input  wire logic       unit0_external_input,
  input  wire logic       unit1_external_input,
  // Interrupt controller
  input  wire logic       ack0,
  input  wire logic       ack1,
  output logic            ovf_irq0,
  output logic            ovf_irq1,
  output logic            irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode_sel;
    logic [7:0] lo0;
    logic [7:0] hi0;
    logic [7:0] lo1;
    logic [7:0] hi1;
    logic [3:0] mc_cnt;
    logic [1:0] s0;
    logic [1:0] s1;
    logic [1:0] sync_pin0;
    logic [1:0] sync_pin1;
    logic       samp0;
    logic       samp1;
    logic [1:0] status;
    logic [1:0] mask;
    logic [7:0] rdata;
  } dtc_state_t;

  dtc_state_t st;
  dtc_state_t next_st;

  logic       mc_tick;
  logic       pin0;
  logic       pin1;
  logic       fall0;
  logic       fall1;
  logic [3:0] nib0;
  logic [3:0] nib1;
  dtc_pkg::dtc_mode_t mode0;
  dtc_pkg::dtc_mode_t mode1;
  logic       run0;
  logic       run1;
  logic       pulse0;
  logic       pulse1;
  logic       pulse_hi0;
  logic       set_ovf0;
  logic       set_ovf1;
  logic       ovf_u1;
  logic [16:0] sum16;
  logic [8:0]  sum8;
  logic [8:0]  sum8b;

  assign pin0     = st.sync_pin0[1];
  assign pin1     = st.sync_pin1[1];
  assign nib0     = st.mode_sel[dtc_pkg::UNIT_NIBBLE-1:0];
  assign nib1     = st.mode_sel[2*dtc_pkg::UNIT_NIBBLE-1:dtc_pkg::UNIT_NIBBLE];
  assign mode0    = dtc_pkg::dtc_mode_t'(nib0[dtc_pkg::BIT_MODE_HI:dtc_pkg::BIT_MODE_LO]);
  assign mode1    = dtc_pkg::dtc_mode_t'(nib1[dtc_pkg::BIT_MODE_HI:dtc_pkg::BIT_MODE_LO]);
  assign ovf_irq0 = st.ctrl[dtc_pkg::BIT_U0_OVF];
  assign ovf_irq1 = st.ctrl[dtc_pkg::BIT_U1_OVF];
  assign rdata    = st.rdata;
  assign irq      = |(st.status & st.mask);

  // ----------------------------------------------------------------
  // Machine cycle and edge detection
  // ----------------------------------------------------------------
  // RULE1: machine cycle enable
  assign mc_tick = (st.mc_cnt == dtc_pkg::MC_LAST);
  // RULE2: edge needs high then low on two samples
  assign fall0 = mc_tick && st.samp0 && !pin0;
  assign fall1 = mc_tick && st.samp1 && !pin1;

  // RULE4: run qualified by gate and pin level
  // RULE8: count enable
  // RULE17: run bit starts and stops
  assign run0 = st.ctrl[dtc_pkg::BIT_U0_RUN] && (!nib0[dtc_pkg::BIT_GATE] || pin0);
  assign run1 = st.ctrl[dtc_pkg::BIT_U1_RUN] && (!nib1[dtc_pkg::BIT_GATE] || pin1);
  // RULE3: choose pin edges or machine cycles
  assign pulse0 = run0 && (nib0[dtc_pkg::BIT_SOURCE] ? fall0 : mc_tick);
  // RULE12: unit 1 frozen in its own mode 3
  assign pulse1 = run1 && (mode1 != dtc_pkg::DTC_MODE_SPLIT)
                  && (nib1[dtc_pkg::BIT_SOURCE] ? fall1 : mc_tick);
  // RULE14: split high byte times cycles under unit 1 run
  assign pulse_hi0 = st.ctrl[dtc_pkg::BIT_U1_RUN] && mc_tick;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st  = st;
    set_ovf0 = 1'b0;
    set_ovf1 = 1'b0;
    ovf_u1   = 1'b0;
    sum16    = 17'h00000;
    sum8     = 9'h000;
    sum8b    = 9'h000;

    next_st.mc_cnt    = mc_tick ? 4'h0 : st.mc_cnt + 4'h1;
    next_st.sync_pin0 = {st.sync_pin0[0], unit0_external_input};
    next_st.sync_pin1 = {st.sync_pin1[0], unit1_external_input};
    if (mc_tick) begin
      next_st.samp0 = pin0;
      next_st.samp1 = pin1;
    end

    // RULE5: unit 0 mode decode
    unique case (mode0)
      dtc_pkg::DTC_MODE_13BIT: begin
        // RULE6: 5-bit prescaler carries into high byte
        if (pulse0) begin
          sum8 = {1'b0, st.lo0 & dtc_pkg::LOW_PRESCALE_MASK} + 9'h001;
          next_st.lo0 = {st.lo0[7:dtc_pkg::PRESCALE_BITS],
                         sum8[dtc_pkg::PRESCALE_BITS-1:0]};
          if (sum8[dtc_pkg::PRESCALE_BITS]) begin
            sum8b = {1'b0, st.hi0} + 9'h001;
            next_st.hi0 = sum8b[7:0];
            set_ovf0 = sum8b[8];
          end
        end
      end
      dtc_pkg::DTC_MODE_16BIT: begin
        // RULE10: full 16-bit count
        if (pulse0) begin
          sum16 = {1'b0, st.hi0, st.lo0} + 17'h00001;
          {next_st.hi0, next_st.lo0} = sum16[15:0];
          set_ovf0 = sum16[16];
        end
      end
      dtc_pkg::DTC_MODE_RELOAD: begin
        // RULE11: reload low from high on overflow
        if (pulse0) begin
          sum8 = {1'b0, st.lo0} + 9'h001;
          next_st.lo0 = sum8[8] ? st.hi0 : sum8[7:0];
          set_ovf0 = sum8[8];
        end
      end
      dtc_pkg::DTC_MODE_SPLIT: begin
        // RULE13: low byte keeps unit 0 controls
        if (pulse0) begin
          sum8 = {1'b0, st.lo0} + 9'h001;
          next_st.lo0 = sum8[7:0];
          set_ovf0 = sum8[8];
        end
        // RULE14: high byte raises unit 1 flag
        if (pulse_hi0) begin
          sum8b = {1'b0, st.hi0} + 9'h001;
          next_st.hi0 = sum8b[7:0];
          set_ovf1 = sum8b[8];
        end
      end
    endcase

    // Unit 1; a split unit 1 mode 3 is held by pulse1 being low
    if (pulse1) begin
      unique case (mode1)
        dtc_pkg::DTC_MODE_13BIT: begin
          sum16 = {4'h0, st.hi1, st.lo1[dtc_pkg::PRESCALE_BITS-1:0]} + 17'h00001;
          next_st.lo1 = {st.lo1[7:dtc_pkg::PRESCALE_BITS],
                         sum16[dtc_pkg::PRESCALE_BITS-1:0]};
          next_st.hi1 = sum16[dtc_pkg::PRESCALE_BITS+7:dtc_pkg::PRESCALE_BITS];
          ovf_u1 = sum16[dtc_pkg::PRESCALE_BITS+8];
        end
        dtc_pkg::DTC_MODE_16BIT: begin
          sum16 = {1'b0, st.hi1, st.lo1} + 17'h00001;
          {next_st.hi1, next_st.lo1} = sum16[15:0];
          ovf_u1 = sum16[16];
        end
        dtc_pkg::DTC_MODE_RELOAD: begin
          sum8 = {1'b0, st.lo1} + 9'h001;
          next_st.lo1 = sum8[8] ? st.hi1 : sum8[7:0];
          ovf_u1 = sum8[8];
        end
        dtc_pkg::DTC_MODE_SPLIT: begin
          ovf_u1 = 1'b0;
        end
      endcase
    end
    // RULE15: unit 1 loses its flag while unit 0 is split
    if (mode0 != dtc_pkg::DTC_MODE_SPLIT) begin
      set_ovf1 = ovf_u1;
    end

    // RULE9: only writes preset the count
    if (wr) begin
      unique case (addr)
        dtc_pkg::ADDR_RUN_FLAG_CTRL: next_st.ctrl     = wdata;
        dtc_pkg::ADDR_MODE_SELECT:   next_st.mode_sel = wdata;
        dtc_pkg::ADDR_U0_LOW:        next_st.lo0      = wdata;
        dtc_pkg::ADDR_U1_LOW:        next_st.lo1      = wdata;
        dtc_pkg::ADDR_U0_HIGH:       next_st.hi0      = wdata;
        dtc_pkg::ADDR_U1_HIGH:       next_st.hi1      = wdata;
        dtc_pkg::ADDR_IRQ_STATUS:    next_st.status   = st.status & ~wdata[1:0];
        dtc_pkg::ADDR_IRQ_MASK:      next_st.mask     = wdata[1:0];
        default: ;
      endcase
    end

    // RULE16: acknowledge clears, set wins over any clear
    // RULE19: service acknowledge per unit
    if (ack0) next_st.ctrl[dtc_pkg::BIT_U0_OVF] = 1'b0;
    if (ack1) next_st.ctrl[dtc_pkg::BIT_U1_OVF] = 1'b0;
    // RULE7: overflow sets the flag
    if (set_ovf0) next_st.ctrl[dtc_pkg::BIT_U0_OVF] = 1'b1;
    if (set_ovf1) next_st.ctrl[dtc_pkg::BIT_U1_OVF] = 1'b1;
    if (set_ovf0) next_st.status[0] = 1'b1;
    if (set_ovf1) next_st.status[1] = 1'b1;

    // Read data stands in the cycle after the strobe only
    next_st.rdata = dtc_pkg::RESET_BYTE;
    if (rd) begin
      unique case (addr)
        // RULE18: external interrupt bits held in the low nibble
        dtc_pkg::ADDR_RUN_FLAG_CTRL: next_st.rdata = st.ctrl;
        dtc_pkg::ADDR_MODE_SELECT:   next_st.rdata = st.mode_sel;
        dtc_pkg::ADDR_U0_LOW:        next_st.rdata = st.lo0;
        dtc_pkg::ADDR_U1_LOW:        next_st.rdata = st.lo1;
        dtc_pkg::ADDR_U0_HIGH:       next_st.rdata = st.hi0;
        dtc_pkg::ADDR_U1_HIGH:       next_st.rdata = st.hi1;
        dtc_pkg::ADDR_IRQ_STATUS:    next_st.rdata = {6'h00, st.status};
        dtc_pkg::ADDR_IRQ_MASK:      next_st.rdata = {6'h00, st.mask};
        default:                     next_st.rdata = dtc_pkg::RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_mc_period: assert property (@(posedge clk) disable iff (rst) // RULE1
    mc_tick |=> !mc_tick [*8] ##1 !mc_tick [*3] ##1 mc_tick)
    else $error("machine cycle not twelve clocks");

  a_ovf_sets_flag: assert property (@(posedge clk) disable iff (rst) // RULE7
    set_ovf0 |=> ovf_irq0)
    else $error("unit 0 overflow flag not set");

  a_u1_freeze: assert property (@(posedge clk) disable iff (rst) // RULE12
    (mode1 == dtc_pkg::DTC_MODE_SPLIT && !wr) |=> $stable({st.hi1, st.lo1}))
    else $error("unit 1 count moved in mode 3");

  a_stop_holds: assert property (@(posedge clk) disable iff (rst) // RULE17
    (!st.ctrl[dtc_pkg::BIT_U0_RUN] && !wr && mode0 != dtc_pkg::DTC_MODE_SPLIT)
      |=> $stable({st.hi0, st.lo0}))
    else $error("unit 0 counted while stopped");

  a_reload_value: assert property (@(posedge clk) disable iff (rst) // RULE11
    (mode0 == dtc_pkg::DTC_MODE_RELOAD && set_ovf0 && !wr)
      |=> st.lo0 == $past(st.hi0) && st.hi0 == $past(st.hi0))
    else $error("reload did not copy high byte");

  a_gate_blocks: assert property (@(posedge clk) disable iff (rst) // RULE8
    (nib0[dtc_pkg::BIT_GATE] && !pin0) |-> !pulse0)
    else $error("gated unit 0 counted with pin low");

  a_split_u1_flag: assert property (@(posedge clk) disable iff (rst) // RULE15
    (mode0 == dtc_pkg::DTC_MODE_SPLIT && ovf_u1 && !pulse_hi0) |-> !set_ovf1)
    else $error("unit 1 raised its flag while unit 0 split");

  a_ack_clears: assert property (@(posedge clk) disable iff (rst) // RULE16
    (ack0 && !set_ovf0) |=> !ovf_irq0)
    else $error("acknowledge did not clear unit 0 flag");

  a_irq_level: assert property (@(posedge clk) disable iff (rst) // RULE19
    $rose(st.status[0]) && st.mask[0] |-> irq)
    else $error("interrupt not raised for unmasked status");

  a_gate_holds: assert property (@(posedge clk) disable iff (rst) // RULE4
    (nib0[dtc_pkg::BIT_GATE] && !pin0 && mode0 != dtc_pkg::DTC_MODE_SPLIT && !wr)
      |=> $stable({st.hi0, st.lo0}))
    else $error("gated unit 0 count moved with pin low");

  a_u1_ovf_flag: assert property (@(posedge clk) disable iff (rst) // RULE7
    set_ovf1 |=> ovf_irq1)
    else $error("unit 1 overflow flag not set");

  a_status_set: assert property (@(posedge clk) disable iff (rst) // RULE16
    set_ovf0 |=> st.status[0])
    else $error("unit 0 status bit not set on overflow");

  a_ack1_clears: assert property (@(posedge clk) disable iff (rst) // RULE19
    (ack1 && !set_ovf1) |=> !ovf_irq1)
    else $error("acknowledge did not clear unit 1 flag");

  a_run_keeps_count: assert property (@(posedge clk) disable iff (rst) // RULE9
    (wr && addr == dtc_pkg::ADDR_RUN_FLAG_CTRL && !pulse0 && mode0 != dtc_pkg::DTC_MODE_SPLIT)
      |=> $stable({st.hi0, st.lo0}))
    else $error("control write changed unit 0 count");

  a_u1_stop_holds: assert property (@(posedge clk) disable iff (rst) // RULE17
    (!st.ctrl[dtc_pkg::BIT_U1_RUN] && !wr) |=> $stable({st.hi1, st.lo1}))
    else $error("unit 1 counted while stopped");

  a_split_high_step: assert property (@(posedge clk) disable iff (rst) // RULE14
    (mode0 == dtc_pkg::DTC_MODE_SPLIT && pulse_hi0 && !wr)
      |=> st.hi0 == $past(st.hi0) + 8'h01)
    else $error("split high byte did not step by one");

  a_split_low_step: assert property (@(posedge clk) disable iff (rst) // RULE13
    (mode0 == dtc_pkg::DTC_MODE_SPLIT && pulse0 && !wr)
      |=> st.lo0 == $past(st.lo0) + 8'h01)
    else $error("split low byte did not step by one");

  a_wide_step: assert property (@(posedge clk) disable iff (rst) // RULE10
    (mode0 == dtc_pkg::DTC_MODE_16BIT && pulse0 && !wr)
      |=> {st.hi0, st.lo0} == $past({st.hi0, st.lo0}) + 16'h0001)
    else $error("unit 0 16-bit count did not step by one");

  a_u0_step13: assert property (@(posedge clk) disable iff (rst) // RULE6
    (mode0 == dtc_pkg::DTC_MODE_13BIT && pulse0 && !wr)
      |=> {st.hi0, st.lo0[dtc_pkg::PRESCALE_BITS-1:0]}
          == $past({st.hi0, st.lo0[dtc_pkg::PRESCALE_BITS-1:0]}) + 13'h0001)
    else $error("unit 0 13-bit count did not step by one");

  a_prescale_top: assert property (@(posedge clk) disable iff (rst) // RULE6
    (mode0 == dtc_pkg::DTC_MODE_13BIT && !wr)
      |=> $stable(st.lo0[7:dtc_pkg::PRESCALE_BITS]))
    else $error("unused low byte bits moved in 13-bit mode");

  a_u1_reload_value: assert property (@(posedge clk) disable iff (rst) // RULE11
    (mode1 == dtc_pkg::DTC_MODE_RELOAD && ovf_u1 && !wr)
      |=> st.lo1 == $past(st.hi1))
    else $error("unit 1 reload did not copy high byte");

  a_pin_fall: assert property (@(posedge clk) disable iff (rst) // RULE2
    fall0 |-> $past(pin0, dtc_pkg::CLOCKS_PER_MACHINE_CYCLE) && !pin0)
    else $error("unit 0 edge seen without high then low samples");

endmodule : dtc_top
`default_nettype wire

// ### hw/dtc_pkg.sv
// Constants and types for the dual timer/counter block
package dtc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RUN_FLAG_CTRL = 8'h88;
  localparam logic [7:0] ADDR_MODE_SELECT   = 8'h89;
  localparam logic [7:0] ADDR_U0_LOW        = 8'h8a;
  localparam logic [7:0] ADDR_U1_LOW        = 8'h8b;
  localparam logic [7:0] ADDR_U0_HIGH       = 8'h8c;
  localparam logic [7:0] ADDR_U1_HIGH       = 8'h8d;
  localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h8e;
  localparam logic [7:0] ADDR_IRQ_MASK      = 8'h8f;
  localparam logic [7:0] RESET_BYTE         = 8'h00;

  // ----------------------------------------------------------------
  // Control register bit positions
  // ----------------------------------------------------------------
  localparam int BIT_U1_OVF    = 7;
  localparam int BIT_U1_RUN    = 6;
  localparam int BIT_U0_OVF    = 5;
  localparam int BIT_U0_RUN    = 4;
  localparam int BIT_IRQ1_EDGE = 3;
  localparam int BIT_IRQ1_TYPE = 2;
  localparam int BIT_IRQ0_EDGE = 1;
  localparam int BIT_IRQ0_TYPE = 0;

  // Mode select fields, per unit nibble: gate, source, mode high, mode low
  localparam int BIT_GATE     = 3;
  localparam int BIT_SOURCE   = 2;
  localparam int BIT_MODE_HI  = 1;
  localparam int BIT_MODE_LO  = 0;
  localparam int UNIT_NIBBLE  = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCKS_PER_MACHINE_CYCLE = 12;
  localparam int PRESCALE_BITS            = 5;
  localparam logic [3:0] MC_LAST          = 4'(CLOCKS_PER_MACHINE_CYCLE - 1);
  localparam logic [7:0] LOW_PRESCALE_MASK = 8'h1f;

  typedef enum logic [1:0] {
    DTC_MODE_13BIT  = 2'b00,
    DTC_MODE_16BIT  = 2'b01,
    DTC_MODE_RELOAD = 2'b10,
    DTC_MODE_SPLIT  = 2'b11
  } dtc_mode_t;
endpackage : dtc_pkg

// ### tb/dtc_pins.sv
// Model of the external count and gate pins
`timescale 1ns/1ns
`default_nettype none

module dtc_pins (
  // Clock
  input  wire logic clk,
  // Pins
  output logic      pin0,
  output logic      pin1
);
  // Idle high, so a gated unit runs unless a test pulls its pin low
  logic [1:0] lvl = 2'b11;

  assign pin0 = lvl[0];
  assign pin1 = lvl[1];

  task automatic hold_level(input int u, input logic v);
    @(posedge clk) lvl[u] <= v;
  endtask : hold_level

  // each level held two machine cycles
  task automatic pulses(input int u, input int n);
    repeat (n) begin
      @(posedge clk) lvl[u] <= 1'b0;
      repeat (24) @(posedge clk);
      lvl[u] <= 1'b1;
      repeat (23) @(posedge clk);
    end
  endtask : pulses
endmodule : dtc_pins
`default_nettype wire

// ### tb/dtc_top_test.sv
// Self-checking bench for the dual timer/counter
`timescale 1ns/1ns
`default_nettype none

module dtc_top_test;
  logic       clk, rst, wr, rd, ack0, ack1, pin0, pin1, ovf_irq0, ovf_irq1, irq;
  logic [7:0] addr, wdata, rdata, got, run;
  int         errors = 0;
  int         checks_done = 0;
  int         l[2], h[2], f[2], m[2], k, dmy, msk;

  dtc_top u_dtc_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .unit0_external_input(pin0), .unit1_external_input(pin1), .ack0(ack0),
    .ack1(ack1), .ovf_irq0(ovf_irq0), .ovf_irq1(ovf_irq1), .irq(irq));
  dtc_pins u_dtc_pins (.clk(clk), .pin0(pin0), .pin1(pin1));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ------------------------------
  // Checks and bus cycles
  // ------------------------------
  task automatic stop_test();
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: byte %h, expected %h", $time, g, e);
    end
  endtask : check_byte

  task automatic check_bit(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: output %b, expected %b", $time, g, e);
    end
  endtask : check_bit

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // Reference count model, one machine tick per loop pass
  function automatic void adv(input int md, input int n, inout int lo, inout int hi,
                              inout int ov);
    int c;
    repeat (n) begin
      case (md)
        0: begin
          c = ((hi << 5) | (lo & 31)) + 1;
          hi = (c >> 5) & 255;
          lo = (lo & 224) | (c & 31);
          if ((c & 8191) == 0) ov = 1;
        end
        1: begin
          c = ((hi << 8) | lo) + 1;
          hi = (c >> 8) & 255;
          lo = c & 255;
          if ((c & 65535) == 0) ov = 1;
        end
        default: begin
          lo = (lo + 1) & 255;
          if (lo == 0) begin
            ov = 1;
            if (md == 2) lo = hi;
          end
        end
      endcase
    end
  endfunction : adv

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    {rst, wr, rd, ack0, ack1, addr, wdata} = '0;
    rst = 1'b1;
    void'($urandom(58787));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wr_reg(8'h90, 8'hff);
    for (int a = 8'h88; a <= 8'h90; a++) begin
      rd_reg(8'(a), got);
      check_byte(got, 8'h00);
    end
    wr_reg(dtc_pkg::ADDR_RUN_FLAG_CTRL, 8'ha5);
    rd_reg(dtc_pkg::ADDR_RUN_FLAG_CTRL, got);
    check_byte(got, 8'ha5);
    check_bit(ovf_irq1, 1'b1);
    @(posedge clk) ack1 <= 1'b1;
    @(posedge clk) ack1 <= 1'b0;
    #1 check_bit(ovf_irq1, 1'b0);
    check_bit(ovf_irq0, 1'b1);
    @(posedge clk) ack0 <= 1'b1;
    @(posedge clk) ack0 <= 1'b0;
    #1 check_bit(ovf_irq0, 1'b0);
    // Every mode on both units; a run window of 12*k clocks gives exactly k ticks
    for (int u = 0; u < 2; u++) begin
      for (int md = 0; md < 4; md++) begin
        repeat (3) begin
          k = 1 + $urandom % 40;
          m[u] = md;
          m[1-u] = (u == 0 && md == 3) ? 1 : 0;
          run = (u == 1) ? 8'h40 : ((md == 3) ? 8'h50 : 8'h10);
          wr_reg(dtc_pkg::ADDR_MODE_SELECT, 8'((m[1] << 4) | m[0]));
          wr_reg(dtc_pkg::ADDR_IRQ_STATUS, 8'h03);
          #1 check_bit(irq, 1'b0);
          for (int i = 0; i < 2; i++) begin
            l[i] = 8'he0 | $urandom % 32;
            h[i] = ($urandom % 2) ? 255 : $urandom % 256;
            f[i] = 0;
            wr_reg(8'(dtc_pkg::ADDR_U0_LOW + i), 8'(l[i]));
            wr_reg(8'(dtc_pkg::ADDR_U0_HIGH + i), 8'(h[i]));
          end
          wr_reg(dtc_pkg::ADDR_RUN_FLAG_CTRL, run);
          repeat (12 * k - 2) @(posedge clk);
          wr_reg(dtc_pkg::ADDR_RUN_FLAG_CTRL, 8'h00);
          if (run[6] && m[1] != 3 && m[0] == 3) adv(m[1], k, l[1], h[1], dmy);
          if (run[6] && m[1] != 3 && m[0] != 3) adv(m[1], k, l[1], h[1], f[1]);
          if (run[6] && m[0] == 3) adv(3, k, h[0], dmy, f[1]);
          if (run[4]) adv(m[0], k, l[0], h[0], f[0]);
          for (int i = 0; i < 2; i++) begin
            rd_reg(8'(dtc_pkg::ADDR_U0_LOW + i), got);
            check_byte(got, 8'(l[i]));
            rd_reg(8'(dtc_pkg::ADDR_U0_HIGH + i), got);
            check_byte(got, 8'(h[i]));
          end
          rd_reg(dtc_pkg::ADDR_IRQ_STATUS, got);
          check_byte(got, 8'((f[1] << 1) | f[0]));
          msk = $urandom % 4;
          wr_reg(dtc_pkg::ADDR_IRQ_MASK, 8'(msk));
          #1 check_bit(irq, |(msk & ((f[1] << 1) | f[0])));
        end
      end
    end
    // Pin edges as count source, then the pin as gate of a timer
    for (int u = 0; u < 2; u++) begin
      k = 1 + $urandom % 5;
      wr_reg(dtc_pkg::ADDR_MODE_SELECT, 8'(5 << (4 * u)));
      wr_reg(8'(dtc_pkg::ADDR_U0_LOW + u), 8'h00);
      wr_reg(8'(dtc_pkg::ADDR_U0_HIGH + u), 8'h00);
      wr_reg(dtc_pkg::ADDR_RUN_FLAG_CTRL, 8'(8'h10 << (2 * u)));
      repeat (30) @(posedge clk);
      u_dtc_pins.pulses(u, k);
      repeat (40) @(posedge clk);
      wr_reg(dtc_pkg::ADDR_RUN_FLAG_CTRL, 8'h00);
      rd_reg(8'(dtc_pkg::ADDR_U0_LOW + u), got);
      check_byte(got, 8'(k));
      wr_reg(dtc_pkg::ADDR_MODE_SELECT, 8'(9 << (4 * u)));
      for (int g = 0; g < 2; g++) begin
        u_dtc_pins.hold_level(u, g[0]);
        repeat (4) @(posedge clk);
        wr_reg(dtc_pkg::ADDR_RUN_FLAG_CTRL, 8'(8'h10 << (2 * u)));
        repeat (34) @(posedge clk);
        wr_reg(dtc_pkg::ADDR_RUN_FLAG_CTRL, 8'h00);
        rd_reg(8'(dtc_pkg::ADDR_U0_LOW + u), got);
        check_byte(got, 8'(k + 3 * g));
      end
    end
    stop_test();
  end
endmodule : dtc_top_test
`default_nettype wire
